// File: logic/gpio_group.sv
// one pin group: its control registers and pad logic
`timescale 1ns/1ps
`default_nettype none
module gpio_group (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    ce,
  // register access for this group
  input  wire logic                    sel,
  input  wire gpio_pkg::reg_req_t      req,
  input  wire logic [7:0]              impl_mask,
  output logic      [7:0]              rdata,
  // pads
  input  wire logic [7:0]              pin_in_schmitt,
  input  wire logic [7:0]              pin_in_ttl,
  input  wire logic [7:0]              periph_en,
  input  wire logic [7:0]              periph_out,
  input  wire logic [7:0]              periph_oe,
  output logic      [7:0]              dig_in,
  output gpio_pkg::pad_ctl_t [7:0]     pad
);

  logic [7:0] lat_q, dir_q, ana_q, wpu_q, thr_q, slr_q, odc_q;
  logic [7:0] lat_d;
  logic [7:0] pin_live;

  // write decode, pin level and latch writes have identical effect
  wire wr_hit = ce & sel & req.wr;
  wire wr_lat = wr_hit & ((req.addr[2:0] == gpio_pkg::IDX_PIN_LEVEL) |
                          (req.addr[2:0] == gpio_pkg::IDX_LATCH));
  // every present bit takes the written byte; every byte write carries all eight
  assign lat_d = (req.wdata & impl_mask) | (pin_live & ~impl_mask);

  // threshold choice feeds reads and peripherals; analog mode forces zero
  genvar n;
  generate
    for (n = 0; n < 8; n++) begin : g_pin
      wire raw  = thr_q[n] ? pin_in_ttl[n] : pin_in_schmitt[n];
      wire hold = periph_en[n] ? periph_out[n] : lat_q[n];
      wire en   = periph_en[n] ? periph_oe[n] : ~dir_q[n];
      assign pin_live[n] = raw & ~ana_q[n] & impl_mask[n];
      assign dig_in[n]   = pin_live[n];
      // open drain only ever pulls low; analog select leaves drive alone
      assign pad[n].out      = odc_q[n] ? 1'b0 : hold;
      assign pad[n].oe       = impl_mask[n] & en & (~odc_q[n] | ~hold);
      assign pad[n].pull_up  = wpu_q[n];
      assign pad[n].ttl_sel  = thr_q[n];
      assign pad[n].slew_lim = slr_q[n];
      assign pad[n].in_en    = ~ana_q[n];
    end
  endgenerate

  // control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lat_q <= gpio_pkg::RST_LATCH;
      dir_q <= gpio_pkg::RST_DIRECTION;
      ana_q <= gpio_pkg::RST_ANALOG;
      wpu_q <= gpio_pkg::RST_PULL_UP;
      thr_q <= gpio_pkg::RST_THRESHOLD;
      slr_q <= gpio_pkg::RST_SLEW;
      odc_q <= gpio_pkg::RST_OPEN_DRN;
    end else if (wr_hit) begin
      if (wr_lat) lat_q <= lat_d & impl_mask;
      if (req.addr[2:0] == gpio_pkg::IDX_DIRECTION)  dir_q <= req.wdata;
      if (req.addr[2:0] == gpio_pkg::IDX_ANALOG)     ana_q <= req.wdata;
      if (req.addr[2:0] == gpio_pkg::IDX_PULL_UP)    wpu_q <= req.wdata;
      if (req.addr[2:0] == gpio_pkg::IDX_THRESHOLD)  thr_q <= req.wdata;
      if (req.addr[2:0] == gpio_pkg::IDX_SLEW)       slr_q <= req.wdata;
      if (req.addr[2:0] == gpio_pkg::IDX_OPEN_DRAIN) odc_q <= req.wdata;
    end
  end

  // read mux, combinational; the top registers it
  always_comb begin
    unique case (req.addr[2:0])
      gpio_pkg::IDX_PIN_LEVEL:  rdata = pin_live;
      gpio_pkg::IDX_LATCH:      rdata = lat_q;
      gpio_pkg::IDX_DIRECTION:  rdata = dir_q;
      gpio_pkg::IDX_ANALOG:     rdata = ana_q;
      gpio_pkg::IDX_PULL_UP:    rdata = wpu_q;
      gpio_pkg::IDX_THRESHOLD:  rdata = thr_q;
      gpio_pkg::IDX_SLEW:       rdata = slr_q;
      gpio_pkg::IDX_OPEN_DRAIN: rdata = odc_q;
    endcase
  end

endmodule
`default_nettype wire

// File: logic/gpio_pkg.sv
// constants and carrier types for the general purpose pin port
// How it works
// - groups present follow pin count: 8 first, 14/16 first+third, 20 all three.
// - every group holds eight control registers, from pin level to open drain.
// - pin level read returns live pins; a write lands in the output latch.
// - pin level write stores the byte into latch for present pins; pins are not kept.
// - latch keeps the latest write via either latch or pin level register.
// - output latch read returns stored value regardless of pin loading.
// - direction 1 disables the driver; direction 0 drives the latch onto pin.
// - direction still governs drivers on pins used as analog inputs.
// - analog select disables digital input; pin reads and routes as zero.
// - analog select never changes the output drive of a pin.
// - after reset every analog select bit is set to analog mode.
// - an enabled peripheral takes the pin from the latch; reads still work.
// - each pull-up bit enables its weak pull-up when 1, off when 0.
// - threshold bit picks schmitt or ttl level for reads and peripherals alike.
// - open drain bit set makes the pin sink only; clear gives push-pull.
// - slew bit set limits the pin's edge rate; clear gives full speed.
package gpio_pkg;

  localparam int GROUPS = 3;
  localparam int PINS   = 8;
  localparam int NPINS  = GROUPS * PINS;

  // package pin counts selecting which groups exist
  localparam int PKG_8  = 8;
  localparam int PKG_14 = 14;
  localparam int PKG_20 = 20;

  // register index inside a group, address = {group, index}
  localparam logic [2:0] IDX_PIN_LEVEL  = 3'h0;
  localparam logic [2:0] IDX_LATCH      = 3'h1;
  localparam logic [2:0] IDX_DIRECTION  = 3'h2;
  localparam logic [2:0] IDX_ANALOG     = 3'h3;
  localparam logic [2:0] IDX_PULL_UP    = 3'h4;
  localparam logic [2:0] IDX_THRESHOLD  = 3'h5;
  localparam logic [2:0] IDX_SLEW       = 3'h6;
  localparam logic [2:0] IDX_OPEN_DRAIN = 3'h7;
  localparam int         ADDR_W         = 5;

  // values after reset
  localparam logic [7:0] RST_LATCH     = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_ANALOG    = 8'hFF;
  localparam logic [7:0] RST_PULL_UP   = 8'h00;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_SLEW      = 8'hFF;
  localparam logic [7:0] RST_OPEN_DRN  = 8'h00;

  // per-pin pad controls
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic ttl_sel;
    logic slew_lim;
    logic in_en;
  } pad_ctl_t;

  // software register request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

endpackage

// File: logic/gpio_port.sv
// top of the general purpose pin port: register port, groups, pad outputs
`timescale 1ns/1ps
`default_nettype none
module gpio_port #(
  parameter int PKG_PINS = 20
) (
  // clock, reset, enable
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  input  wire logic                           ce,
  // register port
  input  wire logic [gpio_pkg::ADDR_W-1:0]    addr,
  input  wire logic [7:0]                     wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic      [7:0]                     rdata,
  // pads, pin n of group g at index g*8+n
  input  wire logic [gpio_pkg::NPINS-1:0]     pin_in_schmitt,
  input  wire logic [gpio_pkg::NPINS-1:0]     pin_in_ttl,
  output logic      [gpio_pkg::NPINS-1:0]     pin_out,
  output logic      [gpio_pkg::NPINS-1:0]     pin_oe,
  output logic      [gpio_pkg::NPINS-1:0]     pull_up_en,
  output logic      [gpio_pkg::NPINS-1:0]     ttl_sel,
  output logic      [gpio_pkg::NPINS-1:0]     slew_lim,
  output logic      [gpio_pkg::NPINS-1:0]     in_buf_en,
  // peripheral routing
  input  wire logic [gpio_pkg::NPINS-1:0]     periph_en,
  input  wire logic [gpio_pkg::NPINS-1:0]     periph_out,
  input  wire logic [gpio_pkg::NPINS-1:0]     periph_oe,
  output logic      [gpio_pkg::NPINS-1:0]     periph_in
);

  // which groups this package has
  localparam logic [2:0] GRP_ON =
    (PKG_PINS >= gpio_pkg::PKG_20) ? 3'h7 :
    (PKG_PINS >= gpio_pkg::PKG_14) ? 3'h5 : 3'h1;

  gpio_pkg::reg_req_t req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  logic [7:0] grp_rd [gpio_pkg::GROUPS];
  logic [gpio_pkg::NPINS-1:0] dig_w;
  gpio_pkg::pad_ctl_t [gpio_pkg::NPINS-1:0] pad_w;
  logic [7:0] rdata_d;

  // one instance per group; absent groups stay fully masked
  genvar g;
  generate
    for (g = 0; g < gpio_pkg::GROUPS; g++) begin : g_grp
      wire [7:0] mask = GRP_ON[g] ? 8'hFF : 8'h00;
      gpio_group u_grp (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .ce             (ce),
        .sel            (addr[4:3] == 2'(g) && GRP_ON[g]),
        .req            (req),
        .impl_mask      (mask),
        .rdata          (grp_rd[g]),
        .pin_in_schmitt (pin_in_schmitt[g*8 +: 8]),
        .pin_in_ttl     (pin_in_ttl[g*8 +: 8]),
        .periph_en      (periph_en[g*8 +: 8]),
        .periph_out     (periph_out[g*8 +: 8]),
        .periph_oe      (periph_oe[g*8 +: 8]),
        .dig_in         (dig_w[g*8 +: 8]),
        .pad            (pad_w[g*8 +: 8])
      );
    end
  endgenerate

  // read select: unmapped or absent group reads zero
  wire [1:0] grp_sel = addr[4:3];
  assign rdata_d = (grp_sel < 2'h3 && GRP_ON[grp_sel]) ? grp_rd[grp_sel] : 8'h00;

  // registered read data, one cycle after the strobe only
  always_ff @(posedge clk_sys) begin
    if (rst) rdata <= 8'h00;
    else if (ce) rdata <= rd ? rdata_d : 8'h00;
  end

  // registered pad outputs, one cycle behind the controls
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_out    <= '0;
      pin_oe     <= '0;
      pull_up_en <= '0;
      ttl_sel    <= '0;
      slew_lim   <= '0;
      in_buf_en  <= '0;
      periph_in  <= '0;
    end else if (ce) begin
      for (int i = 0; i < gpio_pkg::NPINS; i++) begin
        pin_out[i]    <= pad_w[i].out;
        pin_oe[i]     <= pad_w[i].oe;
        pull_up_en[i] <= pad_w[i].pull_up;
        ttl_sel[i]    <= pad_w[i].ttl_sel;
        slew_lim[i]   <= pad_w[i].slew_lim;
        in_buf_en[i]  <= pad_w[i].in_en;
      end
      periph_in <= dig_w;
    end
  end

endmodule
`default_nettype wire

// File: tb/gpio_monitor.sv
// checker on the top ports of the pin port
`timescale 1ns/1ps
`default_nettype none
module gpio_monitor #(
  parameter int PKG_PINS = 20
) (
  // clock and control
  input wire logic        clk_sys,
  input wire logic        rst,
  // register port
  input wire logic [4:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  // pad controls
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pull_up_en,
  input wire logic [23:0] ttl_sel,
  input wire logic [23:0] slew_lim,
  input wire logic [23:0] in_buf_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  // read data only in the cycle after a read, otherwise zero
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata not idle");
  a_absent_zero: assert property (rd && addr[4:3] == 2'b11 |=> rdata == 8'h00)
    else $error("absent group read not zero");
  // pin level or latch write, then a latch read, returns the written byte
  a_latch_back: assert property (wr && addr[4:1] == 4'h0 ##1 rd && addr == 5'h01
    |=> rdata == $past(wdata, 2)) else $error("latch readback wrong");
  a_reset_ctl: assert property ($fell(rst) |-> ##1 (pin_oe == 24'h0 &&
    slew_lim == 24'hFFFFFF && in_buf_en == 24'h0)) else $error("reset pads wrong");
  // control writes reach the pads two cycles on
  a_slew_wr: assert property (wr && addr == 5'h06 |-> ##2 slew_lim[7:0] == $past(wdata, 2))
    else $error("slew pads wrong");
  a_pull_wr: assert property (wr && addr == 5'h04 |-> ##2 pull_up_en[7:0] == $past(wdata, 2))
    else $error("pull-up pads wrong");
  a_ttl_wr: assert property (wr && addr == 5'h05 |-> ##2 ttl_sel[7:0] == $past(wdata, 2))
    else $error("threshold pads wrong");
  a_inbuf_wr: assert property (wr && addr == 5'h03 |-> ##2 in_buf_en[7:0] == ~$past(wdata, 2))
    else $error("input buffer pads wrong");
endmodule
bind gpio_port gpio_monitor #(.PKG_PINS(PKG_PINS)) mon (.clk_sys, .rst, .addr, .wdata, .wr,
  .rd, .rdata, .pin_oe, .pull_up_en, .ttl_sel, .slew_lim, .in_buf_en);
`default_nettype wire

// File: tb/pin_model.sv
// outside circuit on the pads: drive, pull-up and loose lines
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // clock for the loose line pattern
  input  wire logic        clk_sys,
  // pad controls and outside drive; amb marks a level between thresholds
  input  wire logic [23:0] pin_out,
  input  wire logic [23:0] pin_oe,
  input  wire logic [23:0] pull_up_en,
  input  wire logic [23:0] ext_val,
  input  wire logic [23:0] ext_en,
  input  wire logic [23:0] amb,
  // levels seen by the pad inputs
  output logic      [23:0] pin_in_schmitt,
  output logic      [23:0] pin_in_ttl
);
  logic [23:0] loose_q = 24'h555555;
  logic [23:0] lvl;
  logic [23:0] mid;
  // an undriven line flips each cycle so a stale level never passes for a read
  always @(posedge clk_sys) loose_q <= ~loose_q;
  // device driver first, then outside drive, then the pull-up
  assign lvl = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) |
               (~ext_en & (pull_up_en | loose_q))));
  assign mid = ~pin_oe & ext_en & amb;
  // a mid level reads high on ttl and low on schmitt
  assign pin_in_ttl     = lvl | mid;
  assign pin_in_schmitt = lvl & ~mid;
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the pin port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_sys, rst, ce, wr, rd;
  logic [4:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [23:0] pin_out, pin_oe, pull_up_en, ttl_sel, slew_lim, in_buf_en, pin_in_schmitt;
  logic [23:0] pin_in_ttl, periph_en, periph_out, periph_oe, periph_in, ext_val, ext_en, amb;
  int          fail_count, n_checks;
  logic [7:0]  rst_val [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00};
  gpio_port #(.PKG_PINS(20)) dut (.clk_sys, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata,
    .pin_in_schmitt, .pin_in_ttl, .pin_out, .pin_oe, .pull_up_en, .ttl_sel, .slew_lim,
    .in_buf_en, .periph_en, .periph_out, .periph_oe, .periph_in);
  pin_model pads (.clk_sys, .pin_out, .pin_oe, .pull_up_en, .ext_val, .ext_en, .amb,
    .pin_in_schmitt, .pin_in_ttl);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h saw %h", nm, e, s);
    end
  endtask
  // one-cycle strobes, launched at a rising edge; the write strobe is left up
  // so back-to-back writes never assign it twice in one time step, and the
  // next read or settle lowers it
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    check("rdata", rdata, e);
    @(posedge clk_sys);
  endtask
  // pads lag writes by two cycles and periph_in is registered once behind the pins
  task automatic settle;
    wr <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic final_report;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_sys);
    fail_count++;
    final_report;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, ce, wr, rd, addr, wdata} = {4'b1100, 13'h0};
    {periph_en, periph_out, periph_oe, ext_val, ext_en, amb} = '0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) rd_chk(5'(i), rst_val[i]);
    wr_reg(5'h03, 8'h00);
    wr_reg(5'h02, 8'h00);
    wr_reg(5'h01, 8'hA5);
    settle;
    rd_chk(5'h00, 8'hA5);
    wr_reg(5'h00, 8'h3C);
    rd_chk(5'h01, 8'h3C);
    wr_reg(5'h02, 8'hFF);
    ext_en <= 24'hFF;
    ext_val <= 24'h5A;
    settle;
    rd_chk(5'h00, 8'h5A);
    rd_chk(5'h01, 8'h3C);
    wr_reg(5'h03, 8'hFF);
    settle;
    rd_chk(5'h00, 8'h00);
    check("periph_in", periph_in[7:0], 8'h00);
    wr_reg(5'h02, 8'h00);
    settle;
    check("pin_oe", pin_oe[7:0], 8'hFF);
    check("pin_out", pin_out[7:0], 8'h3C);
    // threshold moves both the pin read and periph_in
    wr_reg(5'h03, 8'h00);
    wr_reg(5'h02, 8'hFF);
    amb <= 24'hFF;
    wr_reg(5'h05, 8'hFF);
    settle;
    rd_chk(5'h00, 8'hFF);
    check("periph_in", periph_in[7:0], 8'hFF);
    wr_reg(5'h05, 8'h00);
    settle;
    rd_chk(5'h00, 8'h00);
    check("periph_in", periph_in[7:0], 8'h00);
    ext_en <= 24'h0;
    wr_reg(5'h04, 8'hFF);
    settle;
    rd_chk(5'h00, 8'hFF);
    wr_reg(5'h04, 8'h00);
    wr_reg(5'h06, 8'h00);
    wr_reg(5'h07, 8'hFF);
    wr_reg(5'h02, 8'h00);
    wr_reg(5'h01, 8'h0F);
    settle;
    check("slew_lim", slew_lim[7:0], 8'h00);
    check("pin_oe", pin_oe[7:0], 8'hF0);
    wr_reg(5'h07, 8'h00);
    wr_reg(5'h01, 8'h00);
    {periph_en, periph_out, periph_oe} <= {3{24'h01}};
    settle;
    check("pin_out", pin_out[7:0], 8'h01);
    rd_chk(5'h00, 8'h01);
    periph_en <= 24'h0;
    // a write while the clock enable is low must leave the latch untouched
    ce <= 1'b0;
    wr_reg(5'h01, 8'hFF);
    ce <= 1'b1;
    settle;
    rd_chk(5'h01, 8'h00);
    for (int g = 1; g < 4; g++) begin
      wr_reg({2'(g), 3'h1}, 8'(8'h10 * g));
      rd_chk({2'(g), 3'h1}, (g == 3) ? 8'h00 : 8'(8'h10 * g));
    end
    final_report;
  end
endmodule
`default_nettype wire
